// ==== pkg/orf_defines.svh ====
`ifndef ORF_DEFINES_SVH
`define ORF_DEFINES_SVH
`define ORF_ADDR_FILTER_ZERO 12'h1A6
`define ORF_ADDR_FILTER_ONE 12'h1A7
`define ORF_ADDR_SELECT_ZERO 12'h186
`define ORF_ADDR_SELECT_ONE 12'h187
`define ORF_ADDR_COUNTER_ZERO 12'h0C1
`define ORF_ADDR_COUNTER_ONE 12'h0C2
`define ORF_EVENT_CODE 8'hB7
`define ORF_UMASK_ZERO 8'h01
`define ORF_UMASK_ONE 8'h02
`define ORF_LAT_SELECT 16'h01B7
`define ORF_REQ_LSB 0
`define ORF_REQ_MSB 15
`define ORF_ANY_BIT 16
`define ORF_SUPPLIER_LSB 16
`define ORF_SUPPLIER_MSB 30
`define ORF_L2HIT_BIT 18
`define ORF_SNOOP_LSB 31
`define ORF_SNOOP_MSB 37
`define ORF_LAT_BIT 38
`define ORF_FILTER_ZERO_MASK 64'h0000_0076_8005_FFFF
`define ORF_FILTER_ONE_MASK 64'h0000_0036_8005_FFFF
`define ORF_SUPPLIER_MASK 15'h0004
`define ORF_SNOOP_MASK 7'h6D
`define ORF_FILTER_RESET 64'h0
`define ORF_COUNTER_RESET 40'h0
`define ORF_SELECT_RESET 16'h0
`endif

// ==== pkg/orf_pkg.sv ====
package orf_pkg;
    typedef struct packed {
        logic [15:0] req;
        logic [14:0] supplier;
        logic [6:0] snoop;
    } orf_resp_t;
    typedef struct packed {
        logic [63:0] filter_zero;
        logic [63:0] filter_one;
        logic [15:0] select_zero;
        logic [15:0] select_one;
        logic [39:0] counter_zero;
        logic [39:0] counter_one;
        logic [63:0] rdata;
    } orf_state_t;
endpackage : orf_pkg

// ==== verilog/orf_match.sv ====
`timescale 1ns/1ps
`include "orf_defines.svh"
module orf_match (
    // Filter programming and one offcore response
    input wire logic [63:0] filter,
    input wire orf_pkg::orf_resp_t resp,
    // Outcome
    output logic valid,
    output logic hit
);
    logic any_bit;
    logic pattern_ok;
    logic [14:0] sup_sel;
    logic [6:0] snp_sel;
    always_comb
    begin
        sup_sel = filter[`ORF_SUPPLIER_MSB:`ORF_SUPPLIER_LSB] & `ORF_SUPPLIER_MASK; // [R03] [R07]
        snp_sel = filter[`ORF_SNOOP_MSB:`ORF_SNOOP_LSB] & `ORF_SNOOP_MASK; // [R08]
        any_bit = filter[`ORF_ANY_BIT]; // [R07]
        pattern_ok = any_bit | ((|sup_sel) & (|snp_sel)); // [R10]
        valid = (|filter[`ORF_REQ_MSB:`ORF_REQ_LSB]) & pattern_ok; // [R09]
        // Several classes may be selected at once; any overlap counts. [R12]
        hit = valid & (|(filter[`ORF_REQ_MSB:`ORF_REQ_LSB] & resp.req)) // [R02] [R04] [R05] [R06]
            & (any_bit | ((|(sup_sel & resp.supplier)) & (|(snp_sel & resp.snoop)))); // [R11]
    end
endmodule : orf_match

// ==== verilog/orf_top.sv ====
`timescale 1ns/1ps
`include "orf_defines.svh"
// Behaviour
// [R01] Event B7H counts; umask 01H uses filter zero, 02H filter one.
// [R02] Filter bits 15:0 pick request classes sent to the uncore.
// [R03] Bits 30:16 select supplier info, bits 37:31 select snoop response.
// [R04] Request bits 0-6: demand reads, ownership, fetch, writeback, L2 prefetches.
// [R05] Bits 7-9: partial reads, partial ownership writes, uncached code fetches.
// [R06] Bits 10-15: locks, streams, soft prefetch, L1 prefetch, partial stream, any.
// [R07] Bit 16 any response, bit 18 second-level hit; others reserved.
// [R08] Snoop bits 31,33,34,36,37 select detail; 32 and 35 reserved.
// [R09] No request bit or no valid response pattern gives zero count; the latency sum on counter zero ignores request bits.
// [R10] Pattern valid if any bit, or supplier-OR and snoop-OR both set.
// [R11] With any bit set, supplier and snoop bits are ignored.
// [R12] Multiple request and response bits together count all matching classes.
// [R13] Bit 38, filter zero only, enables average latency measurement.
// [R14] Software clears bits 37:16 and picks request type for latency.
// [R15] Latency on with select 01B7H: counter accumulates outstanding weighted cycles.
// [R16] Software sets counter one to count new requests of that type.
// [R17] Each programmable counter is 40 bits wide.
// [R18] Every cycle the weighted counter adds requests outstanding that cycle.
module orf_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register access port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [11:0] reg_addr,
    input wire logic [63:0] reg_wdata,
    output logic [63:0] reg_rdata,
    // Core request stream
    input wire logic resp_valid,
    input wire orf_pkg::orf_resp_t resp,
    input wire logic [7:0] outstanding,
    // Counter state
    output logic [39:0] counter_zero,
    output logic [39:0] counter_one
);
    orf_pkg::orf_state_t cur_ff;
    orf_pkg::orf_state_t nxt_cur;
    logic [1:0] hit;
    logic [1:0] valid;
    logic lat_on;
    logic [1:0] inc;
    logic [1:0] accum;
    logic [63:0] match_filter_zero;

    // Counter select decode shared by both counters.
    function automatic logic [1:0] sel_filter(input logic [15:0] sel);
        logic [1:0] r;
        r = 2'h0;
        if (sel[7:0] == `ORF_EVENT_CODE && sel[15:8] == `ORF_UMASK_ZERO)
            r = 2'h1; // [R01]
        else if (sel[7:0] == `ORF_EVENT_CODE && sel[15:8] == `ORF_UMASK_ONE)
            r = 2'h2; // [R01]
        return r;
    endfunction : sel_filter

    // ****************************************
    // Matching
    // ****************************************
    // Latency mode runs with bits 37:16 clear, so its response side is taken as any response.
    // Without this the occurrence count on the other counter would see an invalid pattern.
    always_comb
    begin
        match_filter_zero = cur_ff.filter_zero;
        if (cur_ff.filter_zero[`ORF_LAT_BIT])
            match_filter_zero[`ORF_ANY_BIT] = 1'b1; // [R13]
    end

    orf_match u_match_zero (
        .filter(match_filter_zero),
        .resp(resp),
        .valid(valid[0]),
        .hit(hit[0])
    );
    orf_match u_match_one (
        .filter(cur_ff.filter_one),
        .resp(resp),
        .valid(valid[1]),
        .hit(hit[1])
    );

    // ****************************************
    // Counting
    // ****************************************
    // Latency mode takes the request field alone; bits 37:16 are expected clear.
    // The weighted counter wraps silently at 40 bits; nothing here flags an overflow.
    assign lat_on = cur_ff.filter_zero[`ORF_LAT_BIT] & (cur_ff.select_zero == `ORF_LAT_SELECT); // [R13] [R15]

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_cnt
            logic [1:0] fsel;
            logic [15:0] sel;
            assign sel = (g == 0) ? cur_ff.select_zero : cur_ff.select_one;
            assign fsel = sel_filter(sel);
            assign accum[g] = (g == 0) & lat_on;
            assign inc[g] = resp_valid & ((fsel[0] & hit[0]) | (fsel[1] & hit[1])); // [R01] [R09]
        end
    endgenerate

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        nxt_cur = cur_ff;
        if (accum[0])
            nxt_cur.counter_zero = cur_ff.counter_zero + {32'h0, outstanding}; // [R15] [R18]
        else if (inc[0])
            nxt_cur.counter_zero = cur_ff.counter_zero + 40'h1; // [R17]
        if (inc[1])
            nxt_cur.counter_one = cur_ff.counter_one + 40'h1; // [R17]
        // Read data stands for one cycle only; it returns to zero unless read again.
        nxt_cur.rdata = 64'h0;
        if (reg_rd)
        begin
            if (reg_addr == `ORF_ADDR_FILTER_ZERO)
                nxt_cur.rdata = cur_ff.filter_zero;
            else if (reg_addr == `ORF_ADDR_FILTER_ONE)
                nxt_cur.rdata = cur_ff.filter_one;
            else if (reg_addr == `ORF_ADDR_SELECT_ZERO)
                nxt_cur.rdata = {48'h0, cur_ff.select_zero};
            else if (reg_addr == `ORF_ADDR_SELECT_ONE)
                nxt_cur.rdata = {48'h0, cur_ff.select_one};
            else if (reg_addr == `ORF_ADDR_COUNTER_ZERO)
                nxt_cur.rdata = {24'h0, cur_ff.counter_zero};
            else if (reg_addr == `ORF_ADDR_COUNTER_ONE)
                nxt_cur.rdata = {24'h0, cur_ff.counter_one};
        end
        // A software write wins over a count in the same cycle.
        // Reserved filter bits are dropped on write, so they always read back as zero.
        if (reg_wr)
        begin
            if (reg_addr == `ORF_ADDR_FILTER_ZERO)
                nxt_cur.filter_zero = reg_wdata & `ORF_FILTER_ZERO_MASK; // [R07] [R08] [R13]
            else if (reg_addr == `ORF_ADDR_FILTER_ONE)
                nxt_cur.filter_one = reg_wdata & `ORF_FILTER_ONE_MASK; // [R13]
            else if (reg_addr == `ORF_ADDR_SELECT_ZERO)
                nxt_cur.select_zero = reg_wdata[15:0];
            else if (reg_addr == `ORF_ADDR_SELECT_ONE)
                nxt_cur.select_one = reg_wdata[15:0];
            else if (reg_addr == `ORF_ADDR_COUNTER_ZERO)
                nxt_cur.counter_zero = reg_wdata[39:0];
            else if (reg_addr == `ORF_ADDR_COUNTER_ONE)
                nxt_cur.counter_one = reg_wdata[39:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cur_ff <= '{`ORF_FILTER_RESET, `ORF_FILTER_RESET, `ORF_SELECT_RESET, `ORF_SELECT_RESET,
                        `ORF_COUNTER_RESET, `ORF_COUNTER_RESET, 64'h0};
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    assign reg_rdata = cur_ff.rdata;
    assign counter_zero = cur_ff.counter_zero;
    assign counter_one = cur_ff.counter_one;

    // ****************************************
    // Checks
    // ****************************************
    // A write to the counter wins, so a step is only checked in cycles with no register write.
    sequence s_lat_step;
        accum[0] && !reg_wr;
    endsequence

    a_lat_accum: assert property (@(posedge clk) disable iff (rst) // [R18]
        s_lat_step |=> counter_zero == $past(counter_zero) + {32'h0, $past(outstanding)})
        else $error("weighted counter did not add outstanding count");
    a_invalid_zero: assert property (@(posedge clk) disable iff (rst) // [R09]
        (cur_ff.filter_one[15:0] == 16'h0) |-> !valid[1] && !hit[1])
        else $error("filter one without request bits was not refused");
    a_any_ignore: assert property (@(posedge clk) disable iff (rst) // [R11]
        (cur_ff.filter_one[16] && (|(cur_ff.filter_one[15:0] & resp.req))) |-> hit[1])
        else $error("any bit did not override supplier and snoop");
    a_pattern_valid: assert property (@(posedge clk) disable iff (rst) // [R10]
        (|cur_ff.filter_one[15:0] && cur_ff.filter_one[18] && cur_ff.filter_one[31]) |-> valid[1])
        else $error("valid pattern rejected");
    a_count_one: assert property (@(posedge clk) disable iff (rst) // [R01]
        (resp_valid && hit[1] && cur_ff.select_one == 16'h02B7 && !reg_wr)
        |=> counter_one == $past(counter_one) + 40'h1)
        else $error("counter one missed a match on filter one");
    a_no_count: assert property (@(posedge clk) disable iff (rst) // [R01]
        (sel_filter(cur_ff.select_one) == 2'h0 && !reg_wr) |=> $stable(counter_one))
        else $error("counter one moved without offcore select");
    a_reserved_zero: assert property (@(posedge clk) disable iff (rst) // [R07]
        cur_ff.filter_one[17] == 1'b0 && cur_ff.filter_one[38] == 1'b0)
        else $error("reserved filter bit stored");
    a_read_filter: assert property (@(posedge clk) disable iff (rst) // [R02]
        (reg_rd && !reg_wr && reg_addr == `ORF_ADDR_FILTER_ZERO) |=> reg_rdata == $past(cur_ff.filter_zero))
        else $error("filter zero read back wrong");
    a_count_zero: assert property (@(posedge clk) disable iff (rst) // [R01]
        (resp_valid && hit[0] && cur_ff.select_zero == 16'h01B7 && !cur_ff.filter_zero[`ORF_LAT_BIT] && !reg_wr)
        |=> counter_zero == $past(counter_zero) + 40'h1)
        else $error("counter zero missed a match on filter zero");
    a_lat_match: assert property (@(posedge clk) disable iff (rst) // [R13]
        (cur_ff.filter_zero[`ORF_LAT_BIT] && (|cur_ff.filter_zero[15:0])) |-> valid[0])
        else $error("latency filter with a request type was refused");
    a_type_gate: assert property (@(posedge clk) disable iff (rst) // [R02]
        !(|(cur_ff.filter_one[15:0] & resp.req)) |-> !hit[1])
        else $error("hit without a selected request type");
    // The stored filters must never hold a reserved bit, whatever software wrote.
    a_snoop_reserved: assert property (@(posedge clk) disable iff (rst) // [R08]
        !cur_ff.filter_zero[32] && !cur_ff.filter_zero[35] && !cur_ff.filter_one[32] && !cur_ff.filter_one[35])
        else $error("reserved snoop bit stored");
    a_supplier_reserved: assert property (@(posedge clk) disable iff (rst) // [R07]
        cur_ff.filter_zero[30:19] == 12'h0 && !cur_ff.filter_zero[17] && cur_ff.filter_one[30:19] == 12'h0)
        else $error("reserved supplier bit stored");
    a_counter_write: assert property (@(posedge clk) disable iff (rst) // [R17]
        (reg_wr && reg_addr == `ORF_ADDR_COUNTER_ZERO) |=> counter_zero == $past(reg_wdata[39:0]))
        else $error("counter zero write lost");
endmodule : orf_top

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`include "orf_defines.svh"
module tb;
    logic clk, rst, reg_wr, reg_rd, resp_valid;
    logic [11:0] reg_addr;
    logic [63:0] reg_wdata, reg_rdata;
    orf_pkg::orf_resp_t resp;
    logic [7:0] outstanding;
    logic [39:0] counter_zero, counter_one, e;
    int error_cnt, cmp_count;
    orf_top dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .resp_valid(resp_valid), .resp(resp),
        .outstanding(outstanding), .counter_zero(counter_zero), .counter_one(counter_one));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ****************
    // Shared tasks
    // ****************
    task automatic chk(input logic [63:0] act, input logic [63:0] exp, input string msg);
        cmp_count++;
        if (act !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask : chk
    // Each task lets one idle edge pass, so back to back calls never pulse a strobe in one step.
    task automatic wr(input logic [11:0] a, input logic [63:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        @(negedge clk);
    endtask : wr
    // Read data is registered, so it is looked at one edge after the strobe is taken.
    task automatic rd_chk(input logic [11:0] a, input logic [63:0] exp, input string msg);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        chk(reg_rdata, exp, msg);
        @(negedge clk);
    endtask : rd_chk
    task automatic ev(input logic [15:0] rq, input logic [14:0] sp, input logic [6:0] sn);
        resp_valid = 1'b1;
        resp = '{rq, sp, sn};
        @(negedge clk);
        resp_valid = 1'b0;
        @(negedge clk);
    endtask : ev
    // ****************
    // Scenarios
    // ****************
    task automatic t_regs();
        rd_chk(`ORF_ADDR_FILTER_ZERO, 64'h0, "filter zero reset");
        wr(`ORF_ADDR_FILTER_ZERO, '1);
        rd_chk(`ORF_ADDR_FILTER_ZERO, 64'h0000_0076_8005_FFFF, "filter zero mask");
        wr(`ORF_ADDR_FILTER_ONE, '1);
        rd_chk(`ORF_ADDR_FILTER_ONE, 64'h0000_0036_8005_FFFF, "filter one mask");
        rd_chk(12'h3FF, 64'h0, "unmapped read");
        chk({24'h0, counter_zero}, 64'h0, "counter reset");
        $display("t_regs done");
    endtask : t_regs
    task automatic t_types();
        wr(`ORF_ADDR_SELECT_ZERO, 64'h01B7);
        wr(`ORF_ADDR_COUNTER_ZERO, 64'h0);
        e = 40'h0;
        for (int i = 0; i < 16; i++)
        begin
            wr(`ORF_ADDR_FILTER_ZERO, 64'h1_0000 | (64'h1 << i));
            ev(16'h1 << i, 15'h0, 7'h0);
            e++;
            chk({24'h0, counter_zero}, {24'h0, e}, "type match");
            ev(~(16'h1 << i), 15'h7FFF, 7'h7F);
            chk({24'h0, counter_zero}, {24'h0, e}, "type mismatch");
        end
        $display("t_types done");
    endtask : t_types
    task automatic t_resp();
        wr(`ORF_ADDR_FILTER_ZERO, 64'h4_0009);
        ev(16'h0001, 15'h0004, 7'h01);
        chk({24'h0, counter_zero}, {24'h0, e}, "no snoop bit");
        wr(`ORF_ADDR_FILTER_ZERO, 64'h8004_0009);
        ev(16'h0008, 15'h0004, 7'h01);
        e++;
        chk({24'h0, counter_zero}, {24'h0, e}, "supplier and snoop");
        ev(16'h0001, 15'h0004, 7'h02);
        chk({24'h0, counter_zero}, {24'h0, e}, "snoop mismatch");
        wr(`ORF_ADDR_FILTER_ZERO, 64'h1_0000);
        ev(16'hFFFF, 15'h7FFF, 7'h7F);
        chk({24'h0, counter_zero}, {24'h0, e}, "no request bit");
        wr(`ORF_ADDR_FILTER_ONE, 64'h1_0002);
        wr(`ORF_ADDR_SELECT_ONE, 64'h02B7);
        ev(16'h0002, 15'h0, 7'h0);
        chk({24'h0, counter_one}, 64'h1, "filter one count");
        chk({24'h0, counter_zero}, {24'h0, e}, "filter zero idle");
        $display("t_resp done");
    endtask : t_resp
    task automatic t_lat();
        wr(`ORF_ADDR_COUNTER_ZERO, 64'hFF_FFFF_FFFE);
        wr(`ORF_ADDR_FILTER_ZERO, 64'h40_0000_0001);
        outstanding = 8'h03;
        @(negedge clk);
        chk({24'h0, counter_zero}, 64'h1, "latency wrap");
        outstanding = 8'h05;
        @(negedge clk);
        outstanding = 8'h00;
        chk({24'h0, counter_zero}, 64'h6, "latency add");
        wr(`ORF_ADDR_SELECT_ONE, 64'h01B7);
        ev(16'h0001, 15'h0, 7'h0);
        chk({24'h0, counter_one}, 64'h2, "latency occurrences");
        chk({24'h0, counter_zero}, 64'h6, "latency idle");
        $display("t_lat done");
    endtask : t_lat
    task automatic end_sim();
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    initial
    begin
        #20000;
        error_cnt++;
        end_sim();
    end
    initial
    begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 12'h0;
        reg_wdata = 64'h0;
        resp_valid = 1'b0;
        resp = '0;
        outstanding = 8'h00;
        error_cnt = 0;
        cmp_count = 0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        t_regs();
        t_types();
        t_resp();
        t_lat();
        end_sim();
    end
endmodule : tb
